// [core/scs_core.sv]
// spi port with control, status and data registers
`timescale 1ns/1ps
module scs_core (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_sck,
    output logic o_sck,
    output logic o_sck_oe_n,
    input wire logic i_mosi,
    output logic o_mosi,
    output logic o_mosi_oe_n,
    input wire logic i_miso,
    output logic o_miso,
    output logic o_miso_oe_n,
    input wire logic i_ss_n
);
    scs_pkg::scs_ctrl_type ctrl_r;
    scs_pkg::scs_flags_type flags_r;
    scs_pkg::scs_state_type state_r;
    logic [6:0] half_cnt_r;
    logic [6:0] half_lim;
    logic [2:0] rate_code;
    logic [2:0] rate_eff;
    logic [3:0] edge_cnt_r;
    logic [2:0] bit_cnt_r;
    logic slv_act_r;
    logic [7:0] tx_r;
    logic out_bit_r;
    logic [7:0] rx_r;
    logic [7:0] rx_buf_r;
    logic [7:0] rdata_r;
    logic sck_r;
    logic sck_oe_n_r;
    logic mosi_oe_n_r;
    logic miso_oe_n_r;
    logic done_arm_r;
    logic write_collision_flag_arm_r;
    logic mode_fault_flag_arm_r;
    logic sck_lvl;
    logic mosi_lvl;
    logic miso_lvl;
    logic ss_lvl;
    logic sck_prev_r;
    logic ss_prev_r;
    logic ctrl_wr;
    logic stat_rd;
    logic stat_acc;
    logic data_wr;
    logic data_rd;
    logic data_acc;
    logic sel;
    logic busy;
    logic start_ev;
    logic m_edge;
    logic m_lead;
    logic s_edge;
    logic s_lead;
    logic ev_edge;
    logic ev_lead;
    logic sample_ev;
    logic shift_ev;
    logic done_ev;
    logic in_bit;
    logic write_collision_flag_ev;
    logic mode_fault_flag_ev;
    logic slave_select_error_flag_ev;

    scs_sync #(.STAGES(scs_pkg::SYNC_DEPTH), .RESET_VAL(1'b0)) u_sync_sck (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_pin(i_sck),
        .o_lvl(sck_lvl)
    );
    scs_sync #(.STAGES(scs_pkg::SYNC_DEPTH), .RESET_VAL(1'b0)) u_sync_mosi (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_pin(i_mosi),
        .o_lvl(mosi_lvl)
    );
    scs_sync #(.STAGES(scs_pkg::SYNC_DEPTH), .RESET_VAL(1'b0)) u_sync_miso (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_pin(i_miso),
        .o_lvl(miso_lvl)
    );
    scs_sync #(.STAGES(scs_pkg::SYNC_DEPTH), .RESET_VAL(1'b1)) u_sync_ss (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_pin(i_ss_n),
        .o_lvl(ss_lvl)
    );

    // register decode; all three registers open at any time
    // free access
    assign ctrl_wr = i_wr && (i_addr == scs_pkg::ADDR_CTRL);
    assign stat_rd = i_rd && (i_addr == scs_pkg::ADDR_STATUS);
    assign stat_acc = (i_rd || i_wr) && (i_addr == scs_pkg::ADDR_STATUS);
    assign data_wr = i_wr && (i_addr == scs_pkg::ADDR_DATA);
    assign data_rd = i_rd && (i_addr == scs_pkg::ADDR_DATA);
    assign data_acc = data_wr || data_rd;

    // select used unless disabled, but not for slave with phase zero
    assign sel = (ctrl_r.select_pin_disable && ctrl_r.clock_sample_edge) ? 1'b1 : !ss_lvl;

    // half period of 2..64 cycles, reserved codes clamp to nearest
    assign rate_code = {ctrl_r.rate_select_hi, ctrl_r.rate_select_mid, ctrl_r.rate_select_lo};
    assign rate_eff = (rate_code == scs_pkg::RATE_RSV_LO) ? scs_pkg::RATE_MIN :
                      (rate_code == scs_pkg::RATE_RSV_HI) ? scs_pkg::RATE_MAX : rate_code;
    assign half_lim = 7'((8'h01 << rate_eff) - 8'h01);

    assign busy = (state_r == scs_pkg::ST_RUN) || slv_act_r;
    // master starts on a data write when idle
    assign start_ev = data_wr && ctrl_r.port_enable_bit && ctrl_r.master_select && !busy;

    assign m_edge = (state_r == scs_pkg::ST_RUN) && (half_cnt_r == half_lim);
    assign m_lead = !edge_cnt_r[0];
    // slave shifts under the external clock only
    assign s_edge = ctrl_r.port_enable_bit && !ctrl_r.master_select && sel &&
                    (sck_lvl != sck_prev_r);
    assign s_lead = (sck_lvl != ctrl_r.clock_idle_level);
    assign ev_edge = ctrl_r.master_select ? m_edge : s_edge;
    assign ev_lead = ctrl_r.master_select ? m_lead : s_lead;
    // phase zero samples on leading edge, one on trailing
    assign sample_ev = ev_edge && (ev_lead ^ ctrl_r.clock_sample_edge);
    assign shift_ev = ev_edge && !(ev_lead ^ ctrl_r.clock_sample_edge);
    assign in_bit = ctrl_r.master_select ? miso_lvl : mosi_lvl;
    assign done_ev = ctrl_r.master_select ? (m_edge && (edge_cnt_r == scs_pkg::LAST_EDGE)) :
                     (sample_ev && (bit_cnt_r == scs_pkg::LAST_BIT));

    // write while busy is a collision
    assign write_collision_flag_ev = data_wr && busy;
    assign mode_fault_flag_ev = ctrl_r.port_enable_bit && ctrl_r.master_select &&
                     !ctrl_r.select_pin_disable && !ss_lvl;
    // select released in the middle of a byte
    assign slave_select_error_flag_ev = ctrl_r.port_enable_bit && !ctrl_r.master_select && slv_act_r &&
                      !(ctrl_r.select_pin_disable && ctrl_r.clock_sample_edge) &&
                      ss_lvl && !ss_prev_r;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sck_prev_r <= 1'b0;
            ss_prev_r <= 1'b1;
        end else begin
            sck_prev_r <= sck_lvl;
            ss_prev_r <= ss_lvl;
        end
    end

    // control register; a mode fault drops enable and role
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ctrl_r <= scs_pkg::scs_ctrl_type'(scs_pkg::CTRL_RESET);
        end else begin
            if (ctrl_wr) begin
                ctrl_r <= scs_pkg::scs_ctrl_type'(i_wdata);
            end
            // fault disables the port and leaves master role
            if (mode_fault_flag_ev) begin
                ctrl_r.port_enable_bit <= 1'b0;
                ctrl_r.master_select <= 1'b0;
            end
        end
    end

    // master bit clock engine
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_r <= scs_pkg::ST_IDLE;
            half_cnt_r <= 7'h00;
            edge_cnt_r <= 4'h0;
        end else begin
            unique case (state_r)
                scs_pkg::ST_IDLE: begin
                    half_cnt_r <= 7'h00;
                    edge_cnt_r <= 4'h0;
                    if (start_ev) begin
                        state_r <= scs_pkg::ST_RUN;
                    end
                end
                scs_pkg::ST_RUN: begin
                    if (!ctrl_r.port_enable_bit || mode_fault_flag_ev || !ctrl_r.master_select) begin
                        state_r <= scs_pkg::ST_IDLE;
                    end else if (m_edge) begin
                        half_cnt_r <= 7'h00;
                        edge_cnt_r <= edge_cnt_r + 4'h1;
                        if (edge_cnt_r == scs_pkg::LAST_EDGE) begin
                            state_r <= scs_pkg::ST_IDLE;
                        end
                    end else begin
                        half_cnt_r <= half_cnt_r + 7'h01;
                    end
                end
                default: begin
                    state_r <= scs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // serial clock pin; idle level follows control
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sck_r <= 1'b0;
        end else if (m_edge) begin
            sck_r <= !sck_r;
        end else if (state_r == scs_pkg::ST_IDLE) begin
            sck_r <= ctrl_r.clock_idle_level;
        end
    end

    // slave byte tracking
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            slv_act_r <= 1'b0;
            bit_cnt_r <= 3'h0;
        end else if (!ctrl_r.port_enable_bit || ctrl_r.master_select || !sel || slave_select_error_flag_ev) begin
            slv_act_r <= 1'b0;
            bit_cnt_r <= 3'h0;
        end else if (s_edge) begin
            if (sample_ev) begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
            end
            if (done_ev) begin
                slv_act_r <= 1'b0;
            end else if (s_lead) begin
                slv_act_r <= 1'b1;
            end
        end
    end

    // transmit side of the shift register
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            tx_r <= 8'h00;
            out_bit_r <= 1'b0;
        end else if (data_wr) begin
            // write goes straight into the shift register
            if (!ctrl_r.clock_sample_edge) begin
                out_bit_r <= i_wdata[7];
                tx_r <= {i_wdata[6:0], 1'b0};
            end else begin
                tx_r <= i_wdata;
            end
        end else if (shift_ev) begin
            out_bit_r <= tx_r[7];
            tx_r <= {tx_r[6:0], 1'b0};
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rx_r <= 8'h00;
        end else if (sample_ev) begin
            rx_r <= {rx_r[6:0], in_bit};
        end
    end

    // receive buffer loads only at byte end, no reset value
    always_ff @(posedge i_ref_clk) begin
        if (done_ev) begin
            rx_buf_r <= sample_ev ? {rx_r[6:0], in_bit} : rx_r;
        end
    end

    // pins driven only while the port is enabled
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sck_oe_n_r <= 1'b1;
            mosi_oe_n_r <= 1'b1;
            miso_oe_n_r <= 1'b1;
        end else begin
            sck_oe_n_r <= !(ctrl_r.port_enable_bit && ctrl_r.master_select);
            mosi_oe_n_r <= !(ctrl_r.port_enable_bit && ctrl_r.master_select);
            miso_oe_n_r <= !(ctrl_r.port_enable_bit && !ctrl_r.master_select && sel);
        end
    end

    // clearing sequence arms
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            done_arm_r <= 1'b0;
            write_collision_flag_arm_r <= 1'b0;
            mode_fault_flag_arm_r <= 1'b0;
        end else begin
            if (stat_rd && flags_r.transfer_done_flag) begin
                done_arm_r <= 1'b1;
            end else if (data_rd) begin
                done_arm_r <= 1'b0;
            end
            if (stat_acc) begin
                write_collision_flag_arm_r <= 1'b1;
            end else if (data_acc) begin
                write_collision_flag_arm_r <= 1'b0;
            end
            if (stat_rd && flags_r.mode_fault_flag) begin
                mode_fault_flag_arm_r <= 1'b1;
            end else if (ctrl_wr) begin
                mode_fault_flag_arm_r <= 1'b0;
            end
        end
    end

    // status flags; a set in the clearing cycle wins
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            flags_r <= '0;
        end else begin
            // done sets at byte end, clears when a byte starts
            // status read then data read clears it
            if (done_ev) begin
                flags_r.transfer_done_flag <= 1'b1;
            end else if (start_ev || (s_edge && s_lead && !slv_act_r) ||
                         (data_rd && done_arm_r)) begin
                flags_r.transfer_done_flag <= 1'b0;
            end
            // status access then data access clears it
            if (write_collision_flag_ev) begin
                flags_r.write_collision_flag <= 1'b1;
            end else if (data_acc && write_collision_flag_arm_r) begin
                flags_r.write_collision_flag <= 1'b0;
            end
            // only a disabled port clears the select error
            if (slave_select_error_flag_ev) begin
                flags_r.slave_select_error_flag <= 1'b1;
            end else if (!ctrl_r.port_enable_bit) begin
                flags_r.slave_select_error_flag <= 1'b0;
            end
            // status read then control write clears the fault
            if (mode_fault_flag_ev) begin
                flags_r.mode_fault_flag <= 1'b1;
            end else if (ctrl_wr && mode_fault_flag_arm_r) begin
                flags_r.mode_fault_flag <= 1'b0;
            end
        end
    end

    // read data stand one cycle after the strobe
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rdata_r <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                scs_pkg::ADDR_CTRL: rdata_r <= ctrl_r;
                scs_pkg::ADDR_STATUS: begin
                    rdata_r <= 8'h00;
                    rdata_r[scs_pkg::STAT_DONE_POS] <= flags_r.transfer_done_flag;
                    rdata_r[scs_pkg::STAT_WRITE_COLLISION_FLAG_POS] <= flags_r.write_collision_flag;
                    rdata_r[scs_pkg::STAT_SLAVE_SELECT_ERROR_FLAG_POS] <= flags_r.slave_select_error_flag;
                    rdata_r[scs_pkg::STAT_MODE_FAULT_FLAG_POS] <= flags_r.mode_fault_flag;
                end
                scs_pkg::ADDR_DATA: rdata_r <= rx_buf_r;
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign o_rdata = rdata_r;
    assign o_sck = sck_r;
    assign o_sck_oe_n = sck_oe_n_r;
    assign o_mosi = out_bit_r;
    assign o_mosi_oe_n = mosi_oe_n_r;
    assign o_miso = out_bit_r;
    assign o_miso_oe_n = miso_oe_n_r;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_half_step;
        !m_edge ##1 (m_edge || !ctrl_r.port_enable_bit);
    endsequence

    sequence s_done_armed;
        (stat_rd && flags_r.transfer_done_flag && !done_ev) ##1 (!i_rd && !i_wr && !done_ev);
    endsequence

    sequence s_fault_seen;
        mode_fault_flag_ev ##1 (flags_r.mode_fault_flag && !ctrl_r.port_enable_bit);
    endsequence

    a_rate_div_four: assert property (
        (m_edge && rate_code == 3'h1 && edge_cnt_r != 4'hf) |=> s_half_step)
        else $error("divide by four edge spacing wrong");
    a_enable_abort: assert property (
        (!ctrl_r.port_enable_bit && !start_ev) |=> (state_r == scs_pkg::ST_IDLE && !slv_act_r))
        else $error("transfer kept running while disabled");
    a_sck_idle_level: assert property (
        (state_r == scs_pkg::ST_IDLE && $past(state_r) == scs_pkg::ST_IDLE &&
         $stable(ctrl_r.clock_idle_level)) |-> (o_sck == ctrl_r.clock_idle_level))
        else $error("idle clock level wrong");
    a_done_flag_set: assert property (
        done_ev |=> flags_r.transfer_done_flag)
        else $error("done flag not set at byte end");
    a_done_seq_clear: assert property (
        s_done_armed ##1 (data_rd && !done_ev && !stat_rd) |=> !flags_r.transfer_done_flag)
        else $error("done flag not cleared by sequence");
    a_write_collision_flag_on_busy: assert property (
        (data_wr && busy) |=> flags_r.write_collision_flag)
        else $error("collision not flagged");
    a_slave_select_error_flag_sticky: assert property (
        (flags_r.slave_select_error_flag && ctrl_r.port_enable_bit) |=>
        flags_r.slave_select_error_flag)
        else $error("select error cleared while enabled");
    a_fault_effect: assert property (
        s_fault_seen |-> !ctrl_r.master_select)
        else $error("mode fault did not drop master role");
    a_rx_buf_read: assert property (
        data_rd |=> (o_rdata == $past(rx_buf_r)))
        else $error("data read not from receive buffer");
    a_status_reserved: assert property (
        stat_rd |=> (o_rdata[3:0] == 4'h0))
        else $error("reserved status bits not zero");
endmodule

// [core/scs_pkg.sv]
// constants, field layouts and carrier types for the spi control/status/data block
package scs_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'hc3;
    localparam logic [7:0] ADDR_STATUS = 8'hc4;
    localparam logic [7:0] ADDR_DATA = 8'hc5;
    localparam logic [7:0] CTRL_RESET = 8'h14;
    localparam int STAT_DONE_POS = 7;
    localparam int STAT_WRITE_COLLISION_FLAG_POS = 6;
    localparam int STAT_SLAVE_SELECT_ERROR_FLAG_POS = 5;
    localparam int STAT_MODE_FAULT_FLAG_POS = 4;
    localparam logic [2:0] RATE_RSV_LO = 3'h0;
    localparam logic [2:0] RATE_RSV_HI = 3'h7;
    localparam logic [2:0] RATE_MIN = 3'h1;
    localparam logic [2:0] RATE_MAX = 3'h6;
    localparam logic [3:0] LAST_EDGE = 4'hf;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int SYNC_DEPTH = 3;

    typedef struct packed {
        logic rate_select_hi;
        logic port_enable_bit;
        logic select_pin_disable;
        logic master_select;
        logic clock_idle_level;
        logic clock_sample_edge;
        logic rate_select_mid;
        logic rate_select_lo;
    } scs_ctrl_type;

    typedef struct packed {
        logic transfer_done_flag;
        logic write_collision_flag;
        logic slave_select_error_flag;
        logic mode_fault_flag;
    } scs_flags_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } scs_state_type;
endpackage

// [core/scs_sync.sv]
// pin synchroniser that reports a level once the last two stages agree
`timescale 1ns/1ps
module scs_sync #(
    parameter int STAGES = 3,
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_pin,
    output logic o_lvl
);
    logic [STAGES-1:0] q_r;
    logic lvl_r;

    if (STAGES < 3) begin : g_chk
        $error("scs_sync needs at least three stages");
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            q_r <= {STAGES{RESET_VAL}};
        end else begin
            q_r <= {q_r[STAGES-2:0], i_pin};
        end
    end

    // level changes only when the last two stages agree
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            lvl_r <= RESET_VAL;
        end else if (q_r[STAGES-1] == q_r[STAGES-2]) begin
            lvl_r <= q_r[STAGES-1];
        end
    end

    assign o_lvl = lvl_r;
endmodule

// [dv/scs_core_tb_top.sv]
// self-checking bench for the spi control, status and data block
`timescale 1ns/1ps
module scs_core_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic tb_sck = 1'b0;
    logic tb_mosi = 1'b0;
    logic ss_n = 1'b1;
    logic peer_sel_n = 1'b1;
    logic pol = 1'b0;
    logic pha = 1'b0;
    logic [7:0] peer_tx = 8'h00;
    logic [7:0] rdata;
    logic [7:0] peer_rx;
    logic sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, peer_miso;
    int fails = 0;
    int cmp_count = 0;
    wire sck_w = sck_oe_n ? tb_sck : sck_o;
    wire mosi_w = mosi_oe_n ? tb_mosi : mosi_o;
    wire miso_w = miso_oe_n ? peer_miso : miso_o;

    initial begin
        forever #20 clk = ~clk;
    end

    scs_core dut (
        .i_ref_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
        .i_sck(sck_w), .o_sck(sck_o), .o_sck_oe_n(sck_oe_n),
        .i_mosi(mosi_w), .o_mosi(mosi_o), .o_mosi_oe_n(mosi_oe_n),
        .i_miso(miso_w), .o_miso(miso_o), .o_miso_oe_n(miso_oe_n),
        .i_ss_n(ss_n)
    );

    scs_spi_peer peer (
        .i_sck(sck_w), .i_mosi(mosi_w), .i_sel_n(peer_sel_n), .i_clock_idle_level(pol),
        .i_clock_sample_edge(pha), .i_tx(peer_tx), .o_miso(peer_miso), .o_rx(peer_rx)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("compares=%0d mismatches=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d, e);
    endtask

    // serial clock edge spacing in reference cycles
    function automatic int gap_of(input logic [2:0] c);
        if (c == 3'h0) return 2;
        if (c == 3'h7) return 64;
        return 1 << c;
    endfunction

    // one master byte against the peer, optionally with a colliding write
    task automatic xfer(input logic [2:0] c, input bit hit);
        logic [7:0] tx;
        logic [7:0] rx;
        logic prev;
        int n;
        int gap;
        tx = 8'($urandom);
        peer_tx = 8'($urandom);
        pol = 1'($urandom);
        pha = 1'($urandom);
        wr(scs_pkg::ADDR_CTRL, {c[2], 3'b101, pol, pha, c[1:0]});
        repeat (2) @(posedge clk);
        peer_sel_n <= 1'b0;
        chk({7'h00, sck_o}, {7'h00, pol});
        chk({6'h00, sck_oe_n, mosi_oe_n}, 8'h00);
        wr(scs_pkg::ADDR_DATA, tx);
        prev = sck_o;
        n = 0;
        gap = 0;
        for (int k = 0; k < 3000 && n < 16; k++) begin
            @(posedge clk);
            #1;
            if (n == 1) gap++;
            if (sck_o !== prev) begin
                n++;
                prev = sck_o;
                if (hit && n == 4) wr(scs_pkg::ADDR_DATA, ~tx);
            end
        end
        if (n < 16) begin
            fails++;
            summarize();
        end
        chk({7'h00, sck_o}, {7'h00, pol});
        chk(8'(gap), 8'(gap_of(c)));
        repeat (2) @(posedge clk);
        rchk(scs_pkg::ADDR_STATUS, hit ? 8'hc0 : 8'h80);
        rd(scs_pkg::ADDR_DATA, rx);
        if (!hit && gap_of(c) >= 8) chk(rx, peer_tx);
        if (!hit) chk(peer_rx, tx);
        rchk(scs_pkg::ADDR_STATUS, 8'h00);
        peer_sel_n <= 1'b1;
    endtask

    // the bench acts as external master, phase one, low idle clock
    task automatic sbits(input logic [7:0] mb, input int nb, output logic [7:0] got);
        got = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            @(posedge clk);
            tb_mosi <= mb[i];
            tb_sck <= 1'b1;
            repeat (8) @(posedge clk);
            got = {got[6:0], miso_w};
            tb_sck <= 1'b0;
            repeat (8) @(posedge clk);
        end
        tb_mosi <= ~tb_mosi;
    endtask

    initial begin
        logic [7:0] v;
        logic [7:0] mb;
        logic [7:0] got;
        void'($urandom(32'h69c3_45db));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rchk(scs_pkg::ADDR_CTRL, scs_pkg::CTRL_RESET);
        rchk(scs_pkg::ADDR_STATUS, 8'h00);
        rchk(8'h00, 8'h00);
        wr(scs_pkg::ADDR_STATUS, 8'hf0);
        rchk(scs_pkg::ADDR_STATUS, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom) & 8'hbf;
            wr(scs_pkg::ADDR_CTRL, v);
            rchk(scs_pkg::ADDR_CTRL, v);
        end
        for (int c = 0; c < 8; c++) begin
            xfer(3'(c), 1'b0);
        end
        xfer(3'h5, 1'b1);
        wr(scs_pkg::ADDR_CTRL, 8'h5c);
        ss_n <= 1'b0;
        repeat (6) @(posedge clk);
        rchk(scs_pkg::ADDR_STATUS, 8'h10);
        rchk(scs_pkg::ADDR_CTRL, 8'h0c);
        ss_n <= 1'b1;
        repeat (6) @(posedge clk);
        rchk(scs_pkg::ADDR_STATUS, 8'h10);
        wr(scs_pkg::ADDR_CTRL, 8'h3c);
        rchk(scs_pkg::ADDR_STATUS, 8'h00);
        wr(scs_pkg::ADDR_CTRL, 8'h7c);
        ss_n <= 1'b0;
        repeat (6) @(posedge clk);
        rchk(scs_pkg::ADDR_STATUS, 8'h00);
        rchk(scs_pkg::ADDR_CTRL, 8'h7c);
        ss_n <= 1'b1;
        repeat (6) @(posedge clk);
        wr(scs_pkg::ADDR_CTRL, 8'h5f);
        wr(scs_pkg::ADDR_DATA, 8'ha5);
        repeat (20) @(posedge clk);
        wr(scs_pkg::ADDR_CTRL, 8'h1f);
        repeat (3) @(posedge clk);
        chk({7'h00, sck_oe_n}, 8'h01);
        repeat (300) @(posedge clk);
        rchk(scs_pkg::ADDR_STATUS, 8'h00);
        wr(scs_pkg::ADDR_CTRL, 8'hc7);
        v = 8'($urandom);
        mb = 8'($urandom);
        wr(scs_pkg::ADDR_DATA, v);
        ss_n <= 1'b0;
        sbits(mb, 8, got);
        rchk(scs_pkg::ADDR_STATUS, 8'h80);
        rchk(scs_pkg::ADDR_DATA, mb);
        chk(got, v);
        sbits(~mb, 3, got);
        ss_n <= 1'b1;
        repeat (8) @(posedge clk);
        rchk(scs_pkg::ADDR_STATUS, 8'h20);
        wr(scs_pkg::ADDR_CTRL, 8'h87);
        rchk(scs_pkg::ADDR_STATUS, 8'h00);
        summarize();
    end
endmodule

// [dv/scs_spi_peer.sv]
// behavioural spi slave that answers the block in master mode
`timescale 1ns/1ps
module scs_spi_peer (
    input wire logic i_sck,
    input wire logic i_mosi,
    input wire logic i_sel_n,
    input wire logic i_clock_idle_level,
    input wire logic i_clock_sample_edge,
    input wire logic [7:0] i_tx,
    output logic o_miso,
    output logic [7:0] o_rx
);
    logic [7:0] sh;
    initial begin
        o_miso = 1'b0;
        o_rx = 8'h00;
        sh = 8'h00;
    end
    // released line shows the inverse of its last value
    always @(posedge i_sel_n) begin
        o_miso = ~o_miso;
    end
    always @(negedge i_sel_n) begin
        sh = i_tx;
        if (!i_clock_sample_edge) begin
            o_miso = sh[7];
            sh = sh << 1;
        end
    end
    always @(i_sck) begin
        if (!i_sel_n) begin
            if ((i_sck != i_clock_idle_level) != i_clock_sample_edge) begin
                o_rx = {o_rx[6:0], i_mosi};
            end else begin
                o_miso = sh[7];
                sh = sh << 1;
            end
        end
    end
endmodule
